/* File: rtl/three_timer_counter_unit.sv */
// three timer/counter channels with mode, control and count registers
//
// Notes on behaviour
// [RULE_01] gate set and run set: channel counts only while its gate pin high.
// [RULE_02] gate clear: run bit alone enables counting, gate pin ignored.
// [RULE_03] source select clear counts clock, set counts external pin events.
// [RULE_04] mode field: 13-bit, 16-bit, 8-bit reload, special split mode.
// [RULE_05] split mode: channel 0 low byte is 8-bit counter on own controls.
// [RULE_06] split mode: channel 0 high byte is 8-bit timer on channel 1 bits.
// [RULE_07] channel 1 in split mode is held stopped, value unchanged.
// [RULE_08] mode byte: channel 0 low nibble, channel 1 high nibble.
// [RULE_09] ch2 overflow flag set on overflow, not in baud use, sw clears.
// [RULE_10] ch2 external flag set on trigger capture/reload, only sw clears.
// [RULE_11] enabled ch2 interrupt plus external flag requests ch2 vector.
// [RULE_12] receive baud select: ch2 overflows, else ch1 overflows.
// [RULE_13] transmit baud select: ch2 overflows, else ch1 overflows.
// [RULE_14] trigger edge acts only when enabled and not in baud use.
// [RULE_15] ch2 runs while its run bit is one.
// [RULE_16] ch2 source select: clock when 0, falling edges of pin when 1.
// [RULE_17] capture select plus trigger enable: capture count on trigger edge.
// [RULE_18] reload select: reload on overflow and on enabled trigger edges.
// [RULE_19] either baud select forces reload on overflow, no capture.
// [RULE_20] ch0/ch1 overflow flag set on overflow, cleared on vector taken.
// [RULE_21] software starts and stops ch0/ch1 with their run bits.
// [RULE_22] 8-bit reload: high byte copied to low byte, flag set, same cycle.
// [RULE_23] ch2 reload loads from reload pair, capture stores into it.
// [RULE_24] 13-bit mode: low five bits prescale by 32 into high byte.
//
// The strobed register port and the address map were decided locally.
module three_timer_counter_unit (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // register port
  input  wire tcu_pkg::reg_req_s bus,
  output logic [7:0]             rdata,
  // external pins
  input  wire tcu_pkg::pin_in_s  pins,
  // interrupt side of the core
  input  wire logic             ch0_vector_taken,
  input  wire logic             ch1_vector_taken,
  input  wire logic             ch2_int_enable,
  output logic                  ch0_overflow_flag,
  output logic                  ch1_overflow_flag,
  output logic                  ch2_vector_req,
  // serial baud clocks
  output logic                  rx_baud_tick,
  output logic                  tx_baud_tick
);
  import tcu_pkg::*;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] t2c;
    logic       run0;
    logic       run1;
    logic       ovf0;
    logic       ovf1;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] rl2;
    logic [7:0] rh2;
    logic [7:0] rdata;
    logic       rx_tick;
    logic       tx_tick;
  } state_s;

  state_s q;
  state_s next_q;

  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_fall;
  pin_in_s          lvl;
  pin_in_s          fall;

  pin_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .pin    (pins),
    .level  (pin_lvl),
    .fall   (pin_fall)
  );

  assign lvl  = pin_in_s'(pin_lvl);
  assign fall = pin_in_s'(pin_fall);

  // advance one of channels 0/1 by one count in modes 0..2
  function automatic chan_s advance(timer_mode_e m, logic [7:0] lo,
                                    logic [7:0] hi, logic inc);
    chan_s r;
    r.ovf = 1'b0;
    r.lo  = lo;
    r.hi  = hi;
    if (inc) begin
      case (m)
        MODE_13BIT: begin
          if (lo[4:0] == PRE_TOP) begin // [RULE_24]
            r.lo[4:0] = '0;
            r.hi      = hi + 8'h01;
            r.ovf     = (hi == 8'hFF);
          end else begin
            r.lo[4:0] = lo[4:0] + 5'h01;
          end
        end
        MODE_16BIT: begin
          {r.hi, r.lo} = {hi, lo} + 16'h0001;
          r.ovf        = ({hi, lo} == 16'hFFFF);
        end
        MODE_RELOAD8: begin
          if (lo == 8'hFF) begin
            r.lo  = hi; // [RULE_22]
            r.ovf = 1'b1;
          end else begin
            r.lo = lo + 8'h01;
          end
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  // enable term of a gated channel
  function automatic logic gated(logic run, logic gate, logic pin);
    return run & (!gate | pin); // [RULE_01] [RULE_02] [RULE_21]
  endfunction

  timer_mode_e m0;
  timer_mode_e m1;
  logic        inc0;
  logic        inc1;
  logic        inc_th0;
  logic        split0;
  chan_s       c0;
  chan_s       c1;
  logic        ovf_lo0;
  logic        ovf_hi0;
  logic        ovf_t1;
  logic [15:0] cnt2;
  logic [15:0] rld2;
  logic [15:0] next_cnt2;
  logic [15:0] next_rld2;
  logic        inc2;
  logic        baud;
  logic        trig;
  logic        ovf2;

  always_comb begin
    m0     = timer_mode_e'(q.mode[MD_SEL0 +: 2]); // [RULE_04] [RULE_08]
    m1     = timer_mode_e'(q.mode[MD_SEL1 +: 2]); // [RULE_08]
    split0 = (m0 == MODE_SPLIT);

    // [RULE_03]
    inc0 = gated(q.run0, q.mode[MD_GATE0], lvl.gate_pin0)
           & (q.mode[MD_SRC0] ? fall.count_pin0 : 1'b1);
    inc1 = gated(q.run1, q.mode[MD_GATE1], lvl.gate_pin1)
           & (q.mode[MD_SRC1] ? fall.count_pin1 : 1'b1)
           & (m1 != MODE_SPLIT); // [RULE_07]
    // split high byte: plain timer on channel 1 run bit
    inc_th0 = split0 & q.run1; // [RULE_06]

    c0 = advance(m0, q.tl0, q.th0, inc0 & !split0);
    c1 = advance(m1, q.tl1, q.th1, inc1);

    ovf_lo0 = split0 & inc0 & (q.tl0 == 8'hFF); // [RULE_05]
    ovf_hi0 = inc_th0 & (q.th0 == 8'hFF); // [RULE_06]
    ovf_t1  = c1.ovf;

    // channel 2
    cnt2 = {q.th2, q.tl2};
    rld2 = {q.rh2, q.rl2};
    baud = q.t2c[T2_RXB] | q.t2c[T2_TXB];
    inc2 = q.t2c[T2_RUN] // [RULE_15]
           & (q.t2c[T2_SRC] ? fall.count_pin2 : 1'b1); // [RULE_16]
    // baud use takes the trigger pin out of play
    trig = fall.ch2_trigger_pin & q.t2c[T2_TRG] & !baud; // [RULE_14]
    ovf2 = inc2 & (cnt2 == 16'hFFFF);

    next_cnt2 = cnt2;
    next_rld2 = rld2;
    if (inc2) begin
      if (ovf2 & (baud | !q.t2c[T2_CAP])) begin
        next_cnt2 = rld2; // [RULE_18] [RULE_19] [RULE_23]
      end else begin
        next_cnt2 = cnt2 + 16'h0001;
      end
    end
    if (trig) begin
      if (q.t2c[T2_CAP]) begin
        next_rld2 = cnt2; // [RULE_17] [RULE_23]
      end else begin
        next_cnt2 = rld2; // [RULE_18] [RULE_23]
      end
    end

    next_q = q;

    // counters
    if (split0) begin
      next_q.tl0 = inc0 ? q.tl0 + 8'h01 : q.tl0; // [RULE_05]
      next_q.th0 = inc_th0 ? q.th0 + 8'h01 : q.th0; // [RULE_06]
    end else begin
      next_q.tl0 = c0.lo;
      next_q.th0 = c0.hi;
    end
    next_q.tl1 = c1.lo;
    next_q.th1 = c1.hi;
    next_q.tl2 = next_cnt2[7:0];
    next_q.th2 = next_cnt2[15:8];
    next_q.rl2 = next_rld2[7:0];
    next_q.rh2 = next_rld2[15:8];

    // vector taken clears, before software and hardware below
    if (ch0_vector_taken) begin
      next_q.ovf0 = 1'b0; // [RULE_20]
    end
    if (ch1_vector_taken) begin
      next_q.ovf1 = 1'b0; // [RULE_20]
    end

    // software writes; a write beats counting in the same cycle
    if (bus.wr) begin
      case (bus.addr)
        OFS_MODE:  next_q.mode = bus.wdata;
        OFS_T2CTL: next_q.t2c  = bus.wdata;
        OFS_RUN: begin
          next_q.ovf1 = bus.wdata[RF_OVF1];
          next_q.run1 = bus.wdata[RF_RUN1]; // [RULE_21]
          next_q.ovf0 = bus.wdata[RF_OVF0];
          next_q.run0 = bus.wdata[RF_RUN0]; // [RULE_21]
        end
        OFS_TL0:   next_q.tl0 = bus.wdata;
        OFS_TH0:   next_q.th0 = bus.wdata;
        OFS_TL1:   next_q.tl1 = bus.wdata;
        OFS_TH1:   next_q.th1 = bus.wdata;
        OFS_TL2:   next_q.tl2 = bus.wdata;
        OFS_TH2:   next_q.th2 = bus.wdata;
        OFS_RLD2L: next_q.rl2 = bus.wdata;
        OFS_RLD2H: next_q.rh2 = bus.wdata;
        default:   next_q.mode = q.mode;
      endcase
    end

    // hardware sets win over any clear in the same cycle
    if (c0.ovf | ovf_lo0) begin
      next_q.ovf0 = 1'b1; // [RULE_20] [RULE_22] [RULE_05]
    end
    // in split mode the high byte owns the channel 1 flag
    if (split0 ? ovf_hi0 : ovf_t1) begin
      next_q.ovf1 = 1'b1; // [RULE_20] [RULE_06]
    end
    if (ovf2 & !baud) begin
      next_q.t2c[T2_OVF] = 1'b1; // [RULE_09]
    end
    if (trig) begin
      next_q.t2c[T2_EXF] = 1'b1; // [RULE_10]
    end

    // baud clocks
    next_q.rx_tick = q.t2c[T2_RXB] ? ovf2 : ovf_t1; // [RULE_12]
    next_q.tx_tick = q.t2c[T2_TXB] ? ovf2 : ovf_t1; // [RULE_13]

    // read data stands one cycle only
    next_q.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        OFS_MODE:  next_q.rdata = q.mode;
        OFS_T2CTL: next_q.rdata = q.t2c;
        OFS_RUN: begin
          next_q.rdata[RF_OVF1] = q.ovf1;
          next_q.rdata[RF_RUN1] = q.run1;
          next_q.rdata[RF_OVF0] = q.ovf0;
          next_q.rdata[RF_RUN0] = q.run0;
        end
        OFS_TL0:   next_q.rdata = q.tl0;
        OFS_TH0:   next_q.rdata = q.th0;
        OFS_TL1:   next_q.rdata = q.tl1;
        OFS_TH1:   next_q.rdata = q.th1;
        OFS_TL2:   next_q.rdata = q.tl2;
        OFS_TH2:   next_q.rdata = q.th2;
        OFS_RLD2L: next_q.rdata = q.rl2;
        OFS_RLD2H: next_q.rdata = q.rh2;
        default:   next_q.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.mode    <= RST_BYTE;
      q.t2c     <= RST_BYTE;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rdata             = q.rdata;
  assign ch0_overflow_flag = q.ovf0;
  assign ch1_overflow_flag = q.ovf1;
  // either ch2 flag asks for the shared vector
  assign ch2_vector_req    = ch2_int_enable
                             & (q.t2c[T2_OVF] | q.t2c[T2_EXF]); // [RULE_11]
  assign rx_baud_tick      = q.rx_tick;
  assign tx_baud_tick      = q.tx_tick;
endmodule

/* File: rtl/tcu_pkg.sv */
// constants and carriers of the three-channel timer/counter unit
package tcu_pkg;

  // register indices on the plain register port
  localparam logic [3:0] OFS_MODE   = 4'h0;
  localparam logic [3:0] OFS_T2CTL  = 4'h1;
  localparam logic [3:0] OFS_RUN    = 4'h2;
  localparam logic [3:0] OFS_TL0    = 4'h3;
  localparam logic [3:0] OFS_TH0    = 4'h4;
  localparam logic [3:0] OFS_TL1    = 4'h5;
  localparam logic [3:0] OFS_TH1    = 4'h6;
  localparam logic [3:0] OFS_TL2    = 4'h7;
  localparam logic [3:0] OFS_TH2    = 4'h8;
  localparam logic [3:0] OFS_RLD2L  = 4'h9;
  localparam logic [3:0] OFS_RLD2H  = 4'hA;

  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;

  // mode byte fields: channel 1 high nibble, channel 0 low nibble
  localparam int MD_GATE1 = 7;
  localparam int MD_SRC1  = 6;
  localparam int MD_SEL1  = 4;
  localparam int MD_GATE0 = 3;
  localparam int MD_SRC0  = 2;
  localparam int MD_SEL0  = 0;

  // timer2_control fields
  localparam int T2_OVF  = 7;
  localparam int T2_EXF  = 6;
  localparam int T2_RXB  = 5;
  localparam int T2_TXB  = 4;
  localparam int T2_TRG  = 3;
  localparam int T2_RUN  = 2;
  localparam int T2_SRC  = 1;
  localparam int T2_CAP  = 0;

  // run/flag register fields
  localparam int RF_OVF1 = 7;
  localparam int RF_RUN1 = 6;
  localparam int RF_OVF0 = 5;
  localparam int RF_RUN0 = 4;

  // prescaler wrap of the 13-bit mode
  localparam logic [4:0] PRE_TOP = 5'h1F;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic gate_pin1;
    logic gate_pin0;
    logic ch2_trigger_pin;
    logic count_pin2;
    logic count_pin1;
    logic count_pin0;
  } pin_in_s;

  localparam int PIN_W = $bits(pin_in_s);

  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } chan_s;

endpackage

/* File: rtl/pin_sync.sv */
// two-flop synchroniser with falling-edge detect for the external pins
module pin_sync (
  // clock, reset, enable
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // pins in
  input  wire logic [tcu_pkg::PIN_W-1:0] pin,
  // synchronised level and falling-edge pulse
  output logic      [tcu_pkg::PIN_W-1:0] level,
  output logic      [tcu_pkg::PIN_W-1:0] fall
);
  import tcu_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] sync;
    logic [PIN_W-1:0] last;
  } sync_s;

  sync_s q;
  sync_s next_q;

  always_comb begin
    next_q      = q;
    next_q.meta = pin;
    next_q.sync = q.meta;
    next_q.last = q.sync;
  end

  // idle pins assumed high, so no false edge after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '1;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign level = q.sync;
  assign fall  = q.last & ~q.sync;
endmodule

/* File: test/far_side_model.sv */
// far side: external pins and the core's vector acknowledge
module far_side_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // bench commands
  input  wire logic [3:0] fall_req,
  input  wire logic [1:0] gate_lvl,
  input  wire logic       ack_en,
  // unit side
  input  wire logic [1:0] ovf_flag,
  output tcu_pkg::pin_in_s pins,
  output logic [1:0]      taken
);
  import tcu_pkg::*;
  logic [3:0] low;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low <= 4'h0;
      taken <= 2'b00;
    end else begin
      low <= fall_req;
      // one vector per flag, flag drops before a second one
      taken <= ack_en ? (ovf_flag & ~taken) : 2'b00;
    end
  end
  // idle high, a request gives one falling edge
  assign pins = {gate_lvl, ~low};
endmodule

/* File: test/tcu_props.sv */
// port assertions for the timer/counter unit
module tcu_props (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // register port
  input  wire tcu_pkg::reg_req_s bus,
  input  wire logic [7:0]       rdata,
  // pins and core
  input  wire tcu_pkg::pin_in_s  pins,
  input  wire logic             ch0_vector_taken,
  input  wire logic             ch1_vector_taken,
  input  wire logic             ch2_int_enable,
  input  wire logic             ch0_overflow_flag,
  input  wire logic             ch1_overflow_flag,
  input  wire logic             ch2_vector_req,
  input  wire logic             rx_baud_tick,
  input  wire logic             tx_baud_tick
);
  import tcu_pkg::*;
  logic [7:0] mode_sh;
  logic [7:0] t2_sh;
  logic [7:0] run_sh;
  logic       wr_run;
  logic       rx_src;
  logic       tx_src;
  logic       quiet2;
  // only software moves the mode byte and the run and baud-select bits, so their shadows are exact
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_sh <= RST_BYTE;
      t2_sh <= RST_BYTE;
      run_sh <= RST_BYTE;
    end else if (ce && bus.wr) begin
      if (bus.addr == OFS_MODE) mode_sh <= bus.wdata;
      if (bus.addr == OFS_T2CTL) t2_sh <= bus.wdata;
      if (bus.addr == OFS_RUN) run_sh <= bus.wdata;
    end
  end
  assign wr_run = ce && bus.wr && bus.addr == OFS_RUN;
  assign rx_src = t2_sh[T2_RXB] ? t2_sh[T2_RUN] : run_sh[RF_RUN1];
  assign tx_src = t2_sh[T2_TXB] ? t2_sh[T2_RUN] : run_sh[RF_RUN1];
  assign quiet2 = (t2_sh[T2_RXB] | t2_sh[T2_TXB]) && ch2_int_enable
    && !ch2_vector_req && !(bus.wr && bus.addr == OFS_T2CTL);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rx_off; (!rx_src) [*3]; endsequence
  sequence s_tx_off; (!tx_src) [*3]; endsequence
  property p_rd_idle; ce && !bus.rd |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_mode_rb;
    ce && bus.rd && bus.addr == OFS_MODE |=> rdata == $past(mode_sh);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
  property p_unmapped;
    ce && bus.rd && bus.addr > OFS_RLD2H |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_vec_en; !ch2_int_enable |-> !ch2_vector_req; endproperty
  a_vec_en: assert property (p_vec_en) else $error("vector masked");
  property p_flag0_set;
    $rose(ch0_overflow_flag) |-> $past(run_sh[RF_RUN0]) || $past(wr_run);
  endproperty
  a_flag0_set: assert property (p_flag0_set) else $error("flag0 set");
  property p_flag0_clr;
    $fell(ch0_overflow_flag) |-> $past(ch0_vector_taken) || $past(wr_run);
  endproperty
  a_flag0_clr: assert property (p_flag0_clr) else $error("flag0 clr");
  property p_ovf2_baud; $past(quiet2) && ch2_int_enable |-> !ch2_vector_req;
  endproperty
  a_ovf2_baud: assert property (p_ovf2_baud) else $error("ovf2 baud");
  property p_rx_src; s_rx_off |=> !rx_baud_tick; endproperty
  a_rx_src: assert property (p_rx_src) else $error("rx tick source");
  property p_tx_src; s_tx_off |=> !tx_baud_tick; endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx tick source");
endmodule
bind three_timer_counter_unit tcu_props i_props (.clk(clk), .arst_n(arst_n),
  .ce(ce), .bus(bus), .rdata(rdata), .pins(pins),
  .ch0_vector_taken(ch0_vector_taken), .ch1_vector_taken(ch1_vector_taken),
  .ch2_int_enable(ch2_int_enable), .ch0_overflow_flag(ch0_overflow_flag),
  .ch1_overflow_flag(ch1_overflow_flag), .ch2_vector_req(ch2_vector_req),
  .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));

/* File: test/testbench.sv */
// self-checking bench for the timer/counter unit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcu_pkg::*;
  logic clk;
  logic arst_n;
  reg_req_s bus;
  logic [7:0] rdata;
  pin_in_s pins;
  logic [3:0] fall_req;
  logic [1:0] gate_lvl;
  logic ack_en;
  logic ie2;
  logic [1:0] taken;
  logic [1:0] ovf;
  logic vreq;
  logic rxt;
  logic txt;
  logic [55:0] t;
  int errors;
  int n_tests;
  int n_rx = 0;
  int n_tx = 0;
  int n_ack = 0;
  int b;
  int b_tx;
  // mode, run, tl, th, flags {vreq,ovf1,ovf0}, expected tl, th
  logic [55:0] tab [6] = '{56'h0110_FFFF_0101_00, 56'h0210_FF80_0181_80,
    56'h0010_FF07_00E1_08, 56'h0910_0000_0000_00, 56'h0410_0000_0000_00,
    56'h3350_FFFF_0301_01};
  three_timer_counter_unit i_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
    .bus(bus), .rdata(rdata), .pins(pins), .ch0_vector_taken(taken[0]),
    .ch1_vector_taken(taken[1]), .ch2_int_enable(ie2),
    .ch0_overflow_flag(ovf[0]), .ch1_overflow_flag(ovf[1]),
    .ch2_vector_req(vreq), .rx_baud_tick(rxt), .tx_baud_tick(txt));
  far_side_model i_far (.clk(clk), .arst_n(arst_n), .fall_req(fall_req),
    .gate_lvl(gate_lvl), .ack_en(ack_en), .ovf_flag(ovf), .pins(pins),
    .taken(taken));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    n_rx <= n_rx + int'(rxt === 1'b1);
    n_tx <= n_tx + int'(txt === 1'b1);
    n_ack <= n_ack + int'(taken[0] === 1'b1);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic r(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // start, then stop two counts later; flags looked at after the first
  task automatic run2(input logic [3:0] a, input logic [7:0] v,
                      input logic [2:0] f);
    w(a, v);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b1, 1'b0};
    #1 chk({5'h00, vreq, ovf}, {5'h00, f});
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic fall(input logic [3:0] m);
    @(posedge clk);
    fall_req <= m;
    @(posedge clk);
    fall_req <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    errors++;
    give_verdict();
  end
  initial begin
    bus = '0;
    fall_req = 4'h0;
    gate_lvl = 2'b00;
    ack_en = 1'b0;
    ie2 = 1'b0;
    arst_n = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    r(OFS_MODE, RST_BYTE);
    r(OFS_T2CTL, RST_BYTE);
    r(4'hF, 8'h00);
    w(OFS_MODE, 8'h21);
    r(OFS_MODE, 8'h21);
    w(OFS_TL1, 8'h05);
    w(OFS_TH1, 8'h05);
    for (int i = 0; i < 6; i++) begin
      t = tab[i];
      w(OFS_MODE, t[55:48]);
      w(OFS_TL0, t[39:32]);
      w(OFS_TH0, t[31:24]);
      run2(OFS_RUN, t[47:40], t[18:16]);
      r(OFS_TL0, t[15:8]);
      r(OFS_TH0, t[7:0]);
    end
    r(OFS_TL1, 8'h05);
    r(OFS_TH1, 8'h05);
    gate_lvl <= 2'b01;
    w(OFS_MODE, 8'h09);
    w(OFS_TL0, 8'h00);
    run2(OFS_RUN, 8'h10, 3'b000);
    r(OFS_TL0, 8'h02);
    w(OFS_MODE, 8'h05);
    w(OFS_TL0, 8'h00);
    w(OFS_RUN, 8'h10);
    fall(4'h1);
    fall(4'h1);
    w(OFS_RUN, 8'h00);
    r(OFS_TL0, 8'h02);
    w(OFS_MODE, 8'h01);
    w(OFS_TL0, 8'hFF);
    w(OFS_TH0, 8'hFF);
    ack_en <= 1'b1;
    b = n_ack;
    w(OFS_RUN, 8'h10);
    repeat (4) @(posedge clk);
    #1 chk({6'h00, ovf}, 8'h00);
    chk(8'(n_ack - b), 8'h01);
    w(OFS_RUN, 8'h00);
    ack_en <= 1'b0;
    ie2 <= 1'b1;
    w(OFS_TL2, 8'h34);
    w(OFS_TH2, 8'h12);
    w(OFS_T2CTL, 8'h09);
    fall(4'h8);
    r(OFS_RLD2L, 8'h34);
    r(OFS_RLD2H, 8'h12);
    r(OFS_T2CTL, 8'h49);
    chk({7'h00, vreq}, 8'h01);
    w(OFS_T2CTL, 8'h01);
    w(OFS_TL2, 8'h56);
    fall(4'h8);
    r(OFS_RLD2L, 8'h34);
    r(OFS_T2CTL, 8'h01);
    w(OFS_RLD2L, 8'hCD);
    w(OFS_RLD2H, 8'hAB);
    w(OFS_TL2, 8'hFF);
    w(OFS_TH2, 8'hFF);
    run2(OFS_T2CTL, 8'h04, 3'b100);
    r(OFS_TL2, 8'hCE);
    r(OFS_TH2, 8'hAB);
    w(OFS_TL2, 8'hFF);
    w(OFS_TH2, 8'hFF);
    b = n_rx;
    b_tx = n_tx;
    run2(OFS_T2CTL, 8'h34, 3'b000);
    repeat (2) @(posedge clk);
    chk(8'(n_rx - b), 8'h01);
    chk(8'(n_tx - b_tx), 8'h01);
    r(OFS_TL2, 8'hCE);
    w(OFS_T2CTL, 8'h06);
    fall(4'h4);
    fall(4'h4);
    w(OFS_T2CTL, 8'h00);
    r(OFS_TL2, 8'hD0);
    give_verdict();
  end
endmodule
